//--- hw/serial_shift_pkg.sv
package serial_shift_pkg;
  // register indices on the plain port
  localparam logic [2:0] ADDR_DATA   = 3'h0;
  localparam logic [2:0] ADDR_CTRL   = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_PORT   = 3'h3;
  // control register fields
  localparam int CTRL_START_IE = 7;
  localparam int CTRL_OVF_IE   = 6;
  localparam int CTRL_WM_LSB   = 4;
  localparam int CTRL_CS_LSB   = 2;
  localparam int CTRL_CLK      = 1;
  localparam int CTRL_TC       = 0;
  // status register fields
  localparam int STAT_START = 7;
  localparam int STAT_OVF   = 6;
  localparam int STAT_CNT_LSB = 0;
  // port register fields
  localparam int PORT_DO_OUT  = 0;
  localparam int PORT_DO_DIR  = 1;
  localparam int PORT_SDA_OUT = 2;
  localparam int PORT_SDA_DIR = 3;
  localparam int PORT_SCK_OUT = 4;
  localparam int PORT_SCK_DIR = 5;
  // reset values and counter maximum
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [3:0] CNT_MAX    = 4'hF;
  typedef enum logic [1:0] {
    WM_OFF, WM_THREE, WM_TWO, WM_TWO_HOLD
  } wire_mode_t;
  typedef enum logic [1:0] {
    CS_SOFT, CS_TIMER, CS_EXT_POS, CS_EXT_NEG
  } clock_source_t;
endpackage : serial_shift_pkg

//--- hw/serial_shift_unit.sv
`timescale 1ns/10ps
module serial_shift_unit
  import serial_shift_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // register port
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  // companion timer compare match, same clock
  input  wire logic       timerMatch,
  // pins (three-wire data-in doubles as two-wire data line)
  input  wire logic       serialInPin,
  input  wire logic       shiftClockPin,
  output logic            dataOut,
  output logic            dataOutEn,
  output logic            sdaOut,
  output logic            sdaOutEn,
  output logic            sclOut,
  output logic            sclOutEn,
  output logic            pullupEn,
  // interrupt requests
  output logic            startIrq,
  output logic            overflowIrq
);
  logic [7:0] shiftData_q;
  logic [3:0] count_q;
  logic [7:0] ctrl_q;
  logic [7:0] port_q;
  logic       startFlag_q, ovfFlag_q;
  logic       outLatch_q;
  logic       cntOnToggle_q;
  logic       sdaMeta_q, sdaSync_q, sdaPrev_q;
  logic       sckMeta_q, sckSync_q, sckPrev_q;
  wire_mode_t     wireMode;
  clock_source_t  clockSrc;
  logic       twoWire;
  logic       sckRise, sckFall, sdaFall, startSeen;
  logic       wrData, wrCtrl, wrStatus, wrPort;
  logic       clkStrobe, tcStrobe;
  logic       shiftTick, countTick, extSel;

  assign wireMode = wire_mode_t'(ctrl_q[CTRL_WM_LSB +: 2]);
  assign clockSrc = clock_source_t'(ctrl_q[CTRL_CS_LSB +: 2]);
  assign twoWire  = wireMode == WM_TWO || wireMode == WM_TWO_HOLD;
  assign extSel   = ctrl_q[CTRL_CS_LSB + 1];

  // write decode
  assign wrData   = regWr && regAddr == ADDR_DATA;
  assign wrCtrl   = regWr && regAddr == ADDR_CTRL;
  assign wrStatus = regWr && regAddr == ADDR_STATUS;
  assign wrPort   = regWr && regAddr == ADDR_PORT;
  assign clkStrobe = wrCtrl && regWdata[CTRL_CLK];
  assign tcStrobe  = wrCtrl && regWdata[CTRL_TC];

  // two-flop synchronisers plus an edge flop; the first stage is not read further on
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sdaMeta_q <= 1'b1;
      sdaSync_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      sckMeta_q <= 1'b0;
      sckSync_q <= 1'b0;
      sckPrev_q <= 1'b0;
    end else begin
      sdaMeta_q <= serialInPin;
      sdaSync_q <= sdaMeta_q;
      sdaPrev_q <= sdaSync_q;
      sckMeta_q <= shiftClockPin;
      sckSync_q <= sckMeta_q;
      sckPrev_q <= sckSync_q;
    end
  end

  // pin edges; valid because the far clock is at most clk_sys/4
  assign sckRise = sckSync_q && !sckPrev_q;
  assign sckFall = !sckSync_q && sckPrev_q;
  assign sdaFall = !sdaSync_q && sdaPrev_q;
  // start: data line falls while clock line is high, two-wire only
  // limitation: sampled on clk_sys, so no wake from a stopped clock
  assign startSeen = twoWire && sdaFall && sckSync_q;

  // clock source decode
  always_comb begin
    shiftTick = 1'b0;
    countTick = 1'b0;
    unique case (clockSrc)
      CS_SOFT: begin
        shiftTick = clkStrobe;
        countTick = clkStrobe;
      end
      CS_TIMER: begin
        shiftTick = timerMatch;
        countTick = timerMatch;
      end
      CS_EXT_POS: begin
        shiftTick = sckRise;
        countTick = cntOnToggle_q ? tcStrobe : (sckRise || sckFall);
      end
      CS_EXT_NEG: begin
        shiftTick = sckFall;
        countTick = cntOnToggle_q ? tcStrobe : (sckRise || sckFall);
      end
    endcase
  end

  // shift register; a cpu write beats a same-cycle shift
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      shiftData_q <= DATA_RESET;
    end else if (wrData) begin
      shiftData_q <= regWdata;
    end else if (shiftTick) begin
      shiftData_q <= {shiftData_q[6:0], sdaSync_q};
    end
  end

  // four-bit counter, written through the status register
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      count_q <= 4'h0;
    end else if (wrStatus) begin
      count_q <= regWdata[STAT_CNT_LSB +: 4];
    end else if (countTick) begin
      count_q <= count_q + 4'h1;
    end
  end

  // overflow flag; a same-cycle status write blocks the set
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ovfFlag_q <= 1'b0;
    end else if (countTick && count_q == CNT_MAX && !wrStatus) begin
      ovfFlag_q <= 1'b1;
    end else if (wrStatus && regWdata[STAT_OVF]) begin
      ovfFlag_q <= 1'b0;
    end
  end

  // start flag; set beats the write-one clear
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      startFlag_q <= 1'b0;
    end else if (startSeen) begin
      startFlag_q <= 1'b1;
    end else if (wrStatus && regWdata[STAT_START]) begin
      startFlag_q <= 1'b0;
    end
  end

  // control register; strobe bits are not stored except clk select
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RESET;
    end else if (wrCtrl) begin
      ctrl_q <= {regWdata[7:1], 1'b0};
    end
  end

  // counter-on-toggle select; kept apart because the strobe bit reads zero
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cntOnToggle_q <= 1'b0;
    end else if (wrCtrl) begin
      cntOnToggle_q <= regWdata[CTRL_CLK] && regWdata[CTRL_CS_LSB + 1];
    end
  end

  // port register; toggle strobe inverts the clock port bit
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      port_q <= PORT_RESET;
    end else if (wrPort) begin
      port_q <= regWdata;
    end else if (tcStrobe) begin
      port_q[PORT_SCK_OUT] <= !port_q[PORT_SCK_OUT];
    end
  end

  // output latch: opposite edge for external clocks, else follows bit 7
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      outLatch_q <= 1'b0;
    end else if (!extSel) begin
      outLatch_q <= wrData ? regWdata[7] : (shiftTick ? shiftData_q[6] : shiftData_q[7]);
    end else if (clockSrc == CS_EXT_POS ? sckFall : sckRise) begin
      outLatch_q <= shiftData_q[7];
    end
  end

  // pin drive; open-collector lines drive zero when enabled
  // clock hold: start flag, or overflow in two-wire hold mode
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      dataOut   <= 1'b0;
      dataOutEn <= 1'b0;
      sdaOut    <= 1'b0;
      sdaOutEn  <= 1'b0;
      sclOut    <= 1'b0;
      sclOutEn  <= 1'b0;
      pullupEn  <= 1'b1;
    end else begin
      dataOut  <= wireMode == WM_THREE ? outLatch_q : port_q[PORT_DO_OUT];
      dataOutEn <= port_q[PORT_DO_DIR];
      sdaOut   <= 1'b0;
      sclOut   <= 1'b0;
      pullupEn <= !twoWire;
      if (twoWire) begin
        sdaOutEn <= port_q[PORT_SDA_DIR] &&
                    (!outLatch_q || !port_q[PORT_SDA_OUT]);
        sclOutEn <= port_q[PORT_SCK_DIR] &&
                    (!port_q[PORT_SCK_OUT] || startFlag_q ||
                     (wireMode == WM_TWO_HOLD && ovfFlag_q));
      end else begin
        sdaOutEn <= 1'b0;
        sclOutEn <= 1'b0;
      end
    end
  end

  // interrupt requests
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      startIrq    <= 1'b0;
      overflowIrq <= 1'b0;
    end else begin
      startIrq    <= startFlag_q && ctrl_q[CTRL_START_IE];
      overflowIrq <= ovfFlag_q && ctrl_q[CTRL_OVF_IE];
    end
  end

  // read data one cycle after the strobe; data reads the live shifter
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      regRdata <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        ADDR_DATA:   regRdata <= shiftData_q;
        ADDR_CTRL:   regRdata <= {ctrl_q[7:2], 2'b00};
        ADDR_STATUS: regRdata <= {startFlag_q, ovfFlag_q, 2'b00, count_q};
        ADDR_PORT:   regRdata <= port_q;
        default:     regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end
endmodule : serial_shift_unit

//--- tb/serial_shift_monitor.sv
`timescale 1ns/10ps
module serial_shift_monitor
  import serial_shift_pkg::*;
(
  // clock, reset, register port
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  // pins and requests
  input wire logic       dataOutEn,
  input wire logic       sdaOutEn,
  input wire logic       pullupEn,
  input wire logic       startIrq,
  input wire logic       overflowIrq
);
  logic [1:0] modeQ;
  logic [1:0] ieQ;
  logic       dirQ;
  // shadow of control and port fields; pins lag these by one cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      modeQ <= 2'h0;
      ieQ   <= 2'h0;
      dirQ  <= 1'b0;
    end else if (regWr && regAddr == ADDR_CTRL) begin
      modeQ <= regWdata[5:4];
      ieQ   <= regWdata[7:6];
    end else if (regWr && regAddr == ADDR_PORT) begin
      dirQ  <= regWdata[PORT_DO_DIR];
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // three samples so the registered pins have settled
  sequence offRun; (modeQ == WM_OFF)[*3]; endsequence
  sequence twoRun; modeQ[1][*3]; endsequence
  // mode off leaves data-out under port control, so only two-wire drive is off
  mode_off_a: assert property (offRun |-> !sdaOutEn && pullupEn)
    else $error("pins driven in mode off");
  pull_off_a: assert property (twoRun |-> !pullupEn)
    else $error("pull-ups left on");
  rd_idle_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data without read");
  strobe_rd_a: assert property ($past(regRd && regAddr == ADDR_CTRL) |-> regRdata[1:0] == 2'h0)
    else $error("strobe bits read nonzero");
  start_irq_a: assert property (startIrq |-> ieQ[1] || $past(ieQ[1]))
    else $error("start request while disabled");
  ovf_irq_a: assert property (overflowIrq |-> ieQ[0] || $past(ieQ[0]))
    else $error("overflow request while disabled");
  sda_en_a: assert property (sdaOutEn |-> modeQ[1] || $past(modeQ[1]))
    else $error("data line driven outside two-wire");
  do_en_a: assert property (dataOutEn |-> dirQ || $past(dirQ))
    else $error("data-out driven without direction bit");
endmodule : serial_shift_monitor
bind serial_shift_unit serial_shift_monitor serial_shift_monitor_inst (.clk_sys, .nrst, .regAddr,
  .regWdata, .regWr, .regRd, .regRdata, .dataOutEn, .sdaOutEn, .pullupEn, .startIrq, .overflowIrq);

//--- tb/serial_link_partner.sv
`timescale 1ns/10ps
module serial_link_partner (
  // frame request
  input  wire logic       go,
  input  wire logic [7:0] txByte,
  input  wire logic       strt,
  // link pins
  output logic            sck,
  output logic            sdi
);
  // msb first, 200 ns period, an eighth of clk_sys, half the quarter limit
  initial begin
    sck = 1'b0;
    sdi = 1'b1;
  end
  always @(posedge go) begin
    for (int i = 7; i >= 0; i--) begin
      sdi = txByte[i];
      #100 sck = 1'b1;
      #100 sck = 1'b0;
    end
    sdi = ~sdi; // released line must not look stable
  end
  // start condition: data falls while clock is high
  always @(posedge strt) begin
    sdi = 1'b1;
    sck = 1'b1;
    #100 sdi = 1'b0;
    #100 sck = 1'b0;
  end
endmodule : serial_link_partner

//--- tb/universal_serial_shift_interface_bench.sv
`timescale 1ns/10ps
module universal_serial_shift_interface_bench import serial_shift_pkg::*;;
  logic       clk_sys, nrst, regWr, regRd, timerMatch, go, sck, sdi, dataOutEn, overflowIrq;
  logic       strt, sclOutEn, startIrq, pullupEn;
  logic [2:0] regAddr;
  logic [7:0] regWdata, regRdata;
  int         num_errors, samples_checked;
  // rows: address, value written, value read back
  localparam logic [2:0] RA [5] = '{ADDR_DATA, ADDR_CTRL, ADDR_PORT, 3'h5, ADDR_CTRL};
  localparam logic [7:0] WD [5] = '{8'hA5, 8'hF3, 8'h2A, 8'hFF, 8'h00};
  localparam logic [7:0] EX [5] = '{8'hA5, 8'hF0, 8'h2A, 8'h00, 8'h00};
  serial_shift_unit serial_shift_unit_inst (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .timerMatch(timerMatch), .serialInPin(sdi), .shiftClockPin(sck), .dataOut(),
    .dataOutEn(dataOutEn), .sdaOut(), .sdaOutEn(), .sclOut(), .sclOutEn(sclOutEn),
    .pullupEn(pullupEn), .startIrq(startIrq), .overflowIrq(overflowIrq));
  serial_link_partner serial_link_partner_inst (.go(go), .txByte(8'h96), .strt(strt),
    .sck(sck), .sdi(sdi));
  // 40 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr    <= 1'b0;
  endtask : wr
  // read data is only valid the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd   <= 1'b0;
    #1 chk("regRdata", e, regRdata);
  endtask : rd
  task automatic end_sim;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // watchdog far beyond the few microseconds the tests need
  initial begin
    #50000;
    num_errors++;
    end_sim;
  end
  initial begin
    {nrst, regWr, regRd, timerMatch, go, strt, regAddr, regWdata} = '0;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(ADDR_CTRL, CTRL_RESET);
    for (int i = 0; i < 5; i++) begin
      wr(RA[i], WD[i]);
      rd(RA[i], EX[i]);
    end
    // software strobe in three-wire mode, data pin idles high
    wr(ADDR_PORT, 8'h02);
    wr(ADDR_DATA, 8'h81);
    wr(ADDR_CTRL, 8'h12);
    rd(ADDR_DATA, 8'h03);
    chk("dataOutEn", 8'h01, {7'h0, dataOutEn});
    // timer clocking: write collides with a match, then a lone match
    wr(ADDR_CTRL, 8'h14);
    @(posedge clk_sys);
    regWr      <= 1'b1;
    regAddr    <= ADDR_DATA;
    regWdata   <= 8'h5A;
    timerMatch <= 1'b1;
    @(posedge clk_sys);
    regWr      <= 1'b0;
    timerMatch <= 1'b0;
    rd(ADDR_DATA, 8'h5A);
    @(posedge clk_sys);
    timerMatch <= 1'b1;
    @(posedge clk_sys);
    timerMatch <= 1'b0;
    rd(ADDR_DATA, 8'hB5);
    // counter preset to max, external clock in mode off
    wr(ADDR_CTRL, 8'h48);
    wr(ADDR_STATUS, 8'hCF);
    go <= 1'b1;
    repeat (72) @(posedge clk_sys);
    rd(ADDR_STATUS, 8'h4F);
    rd(ADDR_DATA, 8'h96);
    chk("overflowIrq", 8'h01, {7'h0, overflowIrq});
    wr(ADDR_STATUS, 8'h40);
    rd(ADDR_STATUS, 8'h00);
    chk("overflowIrq", 8'h00, {7'h0, overflowIrq});
    // two-wire start condition holds the clock line until the flag clears
    wr(ADDR_PORT, 8'h30);
    wr(ADDR_CTRL, 8'hA0);
    strt <= 1'b1;
    repeat (16) @(posedge clk_sys);
    #1 chk("sclOutEn", 8'h01, {7'h0, sclOutEn});
    chk("startIrq", 8'h01, {7'h0, startIrq});
    chk("pullupEn", 8'h00, {7'h0, pullupEn});
    rd(ADDR_STATUS, 8'h80);
    wr(ADDR_STATUS, 8'h80);
    @(posedge clk_sys);
    #1 chk("sclOutEn", 8'h00, {7'h0, sclOutEn});
    // toggle strobe drives the clock port bit low
    wr(ADDR_CTRL, 8'hA1);
    rd(ADDR_PORT, 8'h20);
    chk("sclOutEn", 8'h01, {7'h0, sclOutEn});
    // reset in mid-run
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(ADDR_DATA, DATA_RESET);
    end_sim;
  end
endmodule : universal_serial_shift_interface_bench
